/* File: logic/qdac_params.svh */
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH

`define QDAC_NCH 4
`define QDAC_RES 16
`define QDAC_FRAME_W 8
`define QDAC_CMD_MSB 7
`define QDAC_CMD_LSB 4
`define QDAC_ADDR_MSB 3
`define QDAC_ADDR_LSB 0
`define QDAC_MASK_MSB 3
`define QDAC_REF_BIT 0
`define QDAC_CMD_NOP 4'h0
`define QDAC_CMD_WRITE 4'h1
`define QDAC_CMD_UPDATE 4'h2
`define QDAC_CMD_WRUPD 4'h3
`define QDAC_CMD_PWRDN 4'h4
`define QDAC_CMD_MASK 4'h5
`define QDAC_CMD_SOFTRST 4'h6
`define QDAC_CMD_REF 4'h7
`define QDAC_POR_CYCLES 16
`define QDAC_SYNC_N 3
`define QDAC_SYNC_INIT 3'h3
`define QDAC_MASK_RESET 4'h0
`define QDAC_REF_RESET 1'h0

`endif

/* File: logic/qdac_pkg.sv */
`default_nettype none
`include "qdac_params.svh"

package qdac_pkg;
   typedef enum logic [3:0] {
      QDAC_NOP = `QDAC_CMD_NOP,
      QDAC_WRITE = `QDAC_CMD_WRITE,
      QDAC_UPDATE = `QDAC_CMD_UPDATE,
      QDAC_WRUPD = `QDAC_CMD_WRUPD,
      QDAC_PWRDN = `QDAC_CMD_PWRDN,
      QDAC_MASK = `QDAC_CMD_MASK,
      QDAC_SOFTRST = `QDAC_CMD_SOFTRST,
      QDAC_REF = `QDAC_CMD_REF
   } qdac_cmd_type;
endpackage : qdac_pkg

`default_nettype wire

/* File: logic/qdac_sync_if.sv */
`default_nettype none

interface qdac_sync_if #(
   parameter int N = 3
);
   logic [N-1:0] raw;
   logic [N-1:0] lvl;
   modport sync (input raw, output lvl);
   modport user (output raw, input lvl);
endinterface : qdac_sync_if

`default_nettype wire

/* File: logic/qdac_sync.sv */
`default_nettype none
`include "qdac_params.svh"

module qdac_sync #(
   parameter int N = `QDAC_SYNC_N,
   parameter logic [N-1:0] INIT = `QDAC_SYNC_INIT
) (
   input wire logic clk,
   input wire logic rstn,
   qdac_sync_if.sync pins
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] lvl;
   } qdac_sync_type;

   qdac_sync_type st_q;
   qdac_sync_type st_d;

   // The accepted level moves only where the second and third stages agree, so a
   // sample caught mid-transition never reaches the user logic.
   always_comb begin
      st_d = st_q;
      st_d.s1 = pins.raw;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < N; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
      end else begin
         st_q <= st_d;
      end
   end

   assign pins.lvl = st_q.lvl;
endmodule : qdac_sync

`default_nettype wire

/* File: logic/qdac_update_ctrl.sv */
// What this block does
// - Strobe high: write waits for falling edge
// - Mask command loads four mask bits
// - Mask resets to zero, pin controls
// - Masked channel ignores strobe edges
// - Write-to-input copies output only when low
// - Update command copies input to output
// - Write-and-update loads both registers
// - Falling strobe updates unmasked channels
// - Strobe held low ignores mask bits
// - Reset pin clears outputs to level
// - Cleared value holds until next write
// - No output updates while reset low
// - Software reset restores power-on state
// - Strobe ignored during power-on reset
// - Power-up level follows select pin
// - Power-up level holds until valid write
// - Reference on at power-up
// - Reference command takes bit zero
// - Frame is command, high, low byte
`default_nettype none
`include "qdac_params.svh"

module qdac_update_ctrl #(
   parameter int NCH = `QDAC_NCH,
   parameter int RES = `QDAC_RES,
   parameter int POR_CYCLES = `QDAC_POR_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic frame_valid,
   input wire logic [`QDAC_FRAME_W-1:0] frame_cmd_byte,
   input wire logic [`QDAC_FRAME_W-1:0] frame_msb,
   input wire logic [`QDAC_FRAME_W-1:0] frame_lsb,
   input wire logic load_strobe_n,
   input wire logic hw_reset_n,
   input wire logic reset_level_select,
   output logic [NCH*RES-1:0] dac_code,
   output logic [NCH*RES-1:0] input_code,
   output logic [NCH-1:0] strobe_mask,
   output logic reference_off,
   output logic init_busy
);
   localparam int POR_W = $clog2(POR_CYCLES + 1);
   localparam logic [RES-1:0] MID_CODE = {1'b1, {(RES-1){1'b0}}};

   if (NCH != `QDAC_NCH || RES < 2 || RES > 2 * `QDAC_FRAME_W || POR_CYCLES < 1) begin : g_bad
      $error("qdac_update_ctrl: unsupported NCH, RES or POR_CYCLES");
   end

   // Both banks share one state word, but a strobe edge moves only the output bank.
   typedef struct packed {
      logic [NCH-1:0][RES-1:0] inreg;
      logic [NCH-1:0][RES-1:0] dac;
      logic [NCH-1:0] mask;
      logic ref_off;
      logic strobe_prev;
      logic [POR_W-1:0] por_cnt;
      logic por_busy;
   } qdac_st_type;

   qdac_st_type st_q;
   qdac_st_type st_d;

   qdac_sync_if #(.N(`QDAC_SYNC_N)) pins ();

   assign pins.raw = {reset_level_select, hw_reset_n, load_strobe_n};

   qdac_sync #(.N(`QDAC_SYNC_N), .INIT(`QDAC_SYNC_INIT)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .pins(pins)
   );

   logic strobe_lvl;
   logic hwrst_lvl;
   logic sel_lvl;
   assign strobe_lvl = pins.lvl[0];
   assign hwrst_lvl = pins.lvl[1];
   assign sel_lvl = pins.lvl[2];

   qdac_pkg::qdac_cmd_type cmd;
   logic [NCH-1:0] addr;
   logic [RES-1:0] data;
   logic [2*`QDAC_FRAME_W-1:0] word;
   assign cmd = qdac_pkg::qdac_cmd_type'(frame_cmd_byte[`QDAC_CMD_MSB:`QDAC_CMD_LSB]);
   assign addr = frame_cmd_byte[`QDAC_ADDR_MSB:`QDAC_ADDR_LSB];
   assign word = {frame_msb, frame_lsb};
   // Data is left aligned, so a narrower resolution drops the low bits of the word.
   assign data = word[2*`QDAC_FRAME_W-1 -: RES];

   logic [RES-1:0] clr_code;
   logic fall;
   logic go;

   assign clr_code = sel_lvl ? MID_CODE : '0;
   // The edge detector resets to the idle level of the pin.
   // This keeps a false falling edge from following reset.
   assign fall = st_q.strobe_prev & ~strobe_lvl;
   assign go = frame_valid & ~st_q.por_busy & hwrst_lvl;

   always_comb begin
      st_d = st_q;
      st_d.strobe_prev = strobe_lvl;
      if (st_q.por_busy) begin
         // The window outlasts the pin synchronisers, so the last clear written
         // here already uses the settled level of the select pin.
         // Power-on ignores strobe
         for (int i = 0; i < NCH; i++) begin
            st_d.inreg[i] = clr_code;
            st_d.dac[i] = clr_code;
         end
         if (st_q.por_cnt == '0) begin
            st_d.por_busy = 1'b0;
         end else begin
            st_d.por_cnt = st_q.por_cnt - 1'b1;
         end
      end else if (!hwrst_lvl) begin
         // Mask and reference survive the pin; only the command registers reset them.
         // Hardware reset clear
         for (int i = 0; i < NCH; i++) begin
            st_d.inreg[i] = clr_code;
            st_d.dac[i] = clr_code;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (fall && !st_q.mask[i]) begin
               st_d.dac[i] = st_q.inreg[i];
            end
         end
         if (go) begin
            case (cmd)
               qdac_pkg::QDAC_WRITE: begin
                  for (int i = 0; i < NCH; i++) begin
                     if (addr[i]) begin
                        st_d.inreg[i] = data;
                        if (!strobe_lvl) begin
                           st_d.dac[i] = data;
                        end
                     end
                  end
               end
               qdac_pkg::QDAC_UPDATE: begin
                  for (int i = 0; i < NCH; i++) begin
                     if (addr[i]) begin
                        st_d.dac[i] = st_q.inreg[i];
                     end
                  end
               end
               qdac_pkg::QDAC_WRUPD: begin
                  for (int i = 0; i < NCH; i++) begin
                     if (addr[i]) begin
                        st_d.inreg[i] = data;
                        st_d.dac[i] = data;
                     end
                  end
               end
               qdac_pkg::QDAC_MASK: begin
                  st_d.mask = frame_lsb[`QDAC_MASK_MSB:0];
               end
               qdac_pkg::QDAC_SOFTRST: begin
                  for (int i = 0; i < NCH; i++) begin
                     st_d.inreg[i] = clr_code;
                     st_d.dac[i] = clr_code;
                  end
                  st_d.mask = `QDAC_MASK_RESET;
                  st_d.ref_off = `QDAC_REF_RESET;
               end
               qdac_pkg::QDAC_REF: begin
                  st_d.ref_off = frame_lsb[`QDAC_REF_BIT];
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q.inreg <= '0;
         st_q.dac <= '0;
         st_q.mask <= `QDAC_MASK_RESET;
         st_q.ref_off <= `QDAC_REF_RESET;
         st_q.strobe_prev <= 1'b1;
         st_q.por_cnt <= POR_W'(POR_CYCLES);
         st_q.por_busy <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign dac_code = st_q.dac;
   assign input_code = st_q.inreg;
   assign strobe_mask = st_q.mask;
   assign reference_off = st_q.ref_off;
   assign init_busy = st_q.por_busy;

   // Helper terms for the assertions only; the state update does not use them.
   logic hold_ok;
   logic mask_cmd;
   logic ref_cmd;
   assign hold_ok = ~st_q.por_busy & hwrst_lvl;
   assign mask_cmd = go & (cmd == qdac_pkg::QDAC_MASK || cmd == qdac_pkg::QDAC_SOFTRST);
   assign ref_cmd = go & (cmd == qdac_pkg::QDAC_REF || cmd == qdac_pkg::QDAC_SOFTRST);

   sequence s_por_release;
      st_q.por_busy ##1 !st_q.por_busy;
   endsequence

   sequence s_quiet;
      !frame_valid && !fall && hold_ok;
   endsequence

   chk_mask_load: assert property (@(posedge clk) disable iff (!rstn)
      (go && cmd == qdac_pkg::QDAC_MASK) |=> st_q.mask == $past(frame_lsb[`QDAC_MASK_MSB:0]))
      else $error("mask not loaded from frame");

   chk_mask_default: assert property (@(posedge clk) disable iff (!rstn)
      s_por_release |-> st_q.mask == `QDAC_MASK_RESET && !st_q.ref_off)
      else $error("mask or reference not at reset value after power-on");

   chk_ref_bit: assert property (@(posedge clk) disable iff (!rstn)
      (go && cmd == qdac_pkg::QDAC_REF) |=> st_q.ref_off == $past(frame_lsb[`QDAC_REF_BIT]))
      else $error("reference control not taken from bit zero");

   chk_soft_reset: assert property (@(posedge clk) disable iff (!rstn)
      (go && cmd == qdac_pkg::QDAC_SOFTRST) |=> st_q.mask == '0 && !st_q.ref_off
      && st_q.dac[0] == $past(clr_code) && st_q.inreg[NCH-1] == $past(clr_code))
      else $error("software reset did not restore power-on state");

   chk_por_level: assert property (@(posedge clk) disable iff (!rstn)
      s_por_release |-> st_q.dac[0] == $past(clr_code) && st_q.dac[NCH-1] == $past(clr_code))
      else $error("power-up level does not follow select pin");

   chk_mask_hold: assert property (@(posedge clk) disable iff (!rstn)
      !mask_cmd |=> $stable(st_q.mask))
      else $error("mask changed without a mask or reset command");

   chk_ref_hold: assert property (@(posedge clk) disable iff (!rstn)
      !ref_cmd |=> $stable(st_q.ref_off))
      else $error("reference control changed without a command");

   chk_frame_drop: assert property (@(posedge clk) disable iff (!rstn)
      (frame_valid && !go) |=> $stable(st_q.mask) && $stable(st_q.ref_off))
      else $error("blocked frame changed a register");

   chk_init_once: assert property (@(posedge clk) disable iff (!rstn)
      !st_q.por_busy |=> !st_q.por_busy)
      else $error("power-on window restarted without reset");

   chk_init_span: assert property (@(posedge clk) disable iff (!rstn)
      (st_q.por_busy && st_q.por_cnt != '0) |=> st_q.por_busy)
      else $error("power-on window ended early");

   // One copy of the channel checks stands beside each output register.
   for (genvar i = 0; i < NCH; i++) begin : g_chk
      chk_defer_write: assert property (@(posedge clk) disable iff (!rstn)
         (go && cmd == qdac_pkg::QDAC_WRITE && addr[i] && strobe_lvl && !fall)
         |=> st_q.inreg[i] == $past(data) && $stable(st_q.dac[i]))
         else $error("deferred write touched output register");

      chk_low_write: assert property (@(posedge clk) disable iff (!rstn)
         (go && cmd == qdac_pkg::QDAC_WRITE && addr[i] && !strobe_lvl)
         |=> st_q.dac[i] == $past(data))
         else $error("write with strobe low did not reach output");

      chk_update_cmd: assert property (@(posedge clk) disable iff (!rstn)
         (go && cmd == qdac_pkg::QDAC_UPDATE && addr[i])
         |=> st_q.dac[i] == $past(st_q.inreg[i]) && $stable(st_q.inreg[i]))
         else $error("update command did not copy input register");

      chk_write_update: assert property (@(posedge clk) disable iff (!rstn)
         (go && cmd == qdac_pkg::QDAC_WRUPD && addr[i])
         |=> st_q.dac[i] == $past(data) && st_q.inreg[i] == $past(data))
         else $error("write-and-update missed a register");

      chk_edge_copy: assert property (@(posedge clk) disable iff (!rstn)
         (fall && hold_ok && !st_q.mask[i] && !frame_valid)
         |=> st_q.dac[i] == $past(st_q.inreg[i]))
         else $error("falling strobe did not update unmasked channel");

      chk_masked_edge: assert property (@(posedge clk) disable iff (!rstn)
         (fall && st_q.mask[i] && hold_ok && !frame_valid) |=> $stable(st_q.dac[i]))
         else $error("masked channel followed strobe edge");

      chk_hw_reset: assert property (@(posedge clk) disable iff (!rstn)
         (!hwrst_lvl && !st_q.por_busy) |=> st_q.dac[i] == $past(clr_code))
         else $error("reset pin did not clear output");

      chk_hold_quiet: assert property (@(posedge clk) disable iff (!rstn)
         s_quiet |=> $stable(st_q.dac[i]))
         else $error("output moved without a write or edge");

      chk_por_ignore: assert property (@(posedge clk) disable iff (!rstn)
         (st_q.por_busy && fall) |=> st_q.dac[i] == $past(clr_code))
         else $error("strobe edge acted during power-on");

      chk_init_level: assert property (@(posedge clk) disable iff (!rstn)
         st_q.por_busy |=> st_q.dac[i] == $past(clr_code))
         else $error("output left clear level during power-on");

      chk_low_masked: assert property (@(posedge clk) disable iff (!rstn)
         (go && cmd == qdac_pkg::QDAC_WRITE && addr[i] && !strobe_lvl && st_q.mask[i])
         |=> st_q.dac[i] == $past(data))
         else $error("low strobe write blocked by mask");

      chk_addr_select: assert property (@(posedge clk) disable iff (!rstn)
         (go && (cmd == qdac_pkg::QDAC_WRITE || cmd == qdac_pkg::QDAC_WRUPD) && !addr[i])
         |=> $stable(st_q.inreg[i]))
         else $error("write reached an unaddressed channel");

      chk_reset_input: assert property (@(posedge clk) disable iff (!rstn)
         (!hwrst_lvl && !st_q.por_busy) |=> st_q.inreg[i] == $past(clr_code))
         else $error("input register not cleared while reset low");

      chk_soft_clear: assert property (@(posedge clk) disable iff (!rstn)
         (go && cmd == qdac_pkg::QDAC_SOFTRST)
         |=> st_q.dac[i] == $past(clr_code) && st_q.inreg[i] == $past(clr_code))
         else $error("software reset left a channel uncleared");
   end
endmodule : qdac_update_ctrl

`default_nettype wire

/* File: tb/qdac_master_model.sv */
`default_nettype none
`include "qdac_params.svh"

module qdac_master_model #(
   parameter int GAP = 1
) (
   input wire logic clk,
   output logic frame_valid,
   output logic [`QDAC_FRAME_W-1:0] frame_cmd_byte,
   output logic [`QDAC_FRAME_W-1:0] frame_msb,
   output logic [`QDAC_FRAME_W-1:0] frame_lsb
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      frame_valid = 1'b0;
      frame_cmd_byte = 8'h00;
      frame_msb = 8'h00;
      frame_lsb = 8'h00;
   end

   // Bytes stay whole.
   // The three bytes are presented together for one cycle, in command, high, low order.
   // Between frames the bytes show the inverse of the last frame, so stale data never matches.
   task automatic send(input logic [7:0] c, input logic [7:0] m, input logic [7:0] l);
      @(posedge clk);
      frame_valid <= 1'b1;
      frame_cmd_byte <= c;
      frame_msb <= m;
      frame_lsb <= l;
      @(posedge clk);
      frame_valid <= 1'b0;
      frame_cmd_byte <= ~c;
      frame_msb <= ~m;
      frame_lsb <= ~l;
      repeat (GAP) @(posedge clk);
   endtask : send
endmodule : qdac_master_model

`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
`include "qdac_params.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MID = 16'h8000;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic load_strobe_n = 1'b1;
   logic hw_reset_n = 1'b1;
   logic reset_level_select = 1'b1;
   logic frame_valid;
   logic [7:0] frame_cmd_byte;
   logic [7:0] frame_msb;
   logic [7:0] frame_lsb;
   logic [63:0] dac_code;
   logic [63:0] input_code;
   logic [3:0] strobe_mask;
   logic reference_off;
   logic init_busy;
   int fails = 0;
   int checked = 0;

   always #2 clk = ~clk;

   qdac_master_model #(.GAP(1)) i_master (
      .clk(clk),
      .frame_valid(frame_valid),
      .frame_cmd_byte(frame_cmd_byte),
      .frame_msb(frame_msb),
      .frame_lsb(frame_lsb)
   );

   qdac_update_ctrl #(.NCH(4), .RES(16), .POR_CYCLES(16)) i_dut (
      .clk(clk),
      .rstn(rstn),
      .frame_valid(frame_valid),
      .frame_cmd_byte(frame_cmd_byte),
      .frame_msb(frame_msb),
      .frame_lsb(frame_lsb),
      .load_strobe_n(load_strobe_n),
      .hw_reset_n(hw_reset_n),
      .reset_level_select(reset_level_select),
      .dac_code(dac_code),
      .input_code(input_code),
      .strobe_mask(strobe_mask),
      .reference_off(reference_off),
      .init_busy(init_busy)
   );

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_reg(input logic [4:0] got, input logic [4:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   // Pin levels need two agreeing samples, so eight cycles covers the synchroniser.
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk

   task automatic t_por;
      int n;
      n = 0;
      // The strobe falls inside the power-on window and must leave no trace.
      load_strobe_n <= 1'b0;
      wait_clk(6);
      chk_reg({4'h0, init_busy}, 5'h01); // Init still running.
      chk(dac_code, {4{MID}}); // Strobe fall ignored in init.
      @(posedge clk) load_strobe_n <= 1'b1;
      while (init_busy !== 1'b0 && n < 100) begin
         wait_clk(1);
         n++;
      end
      chk_reg({4'h0, init_busy}, 5'h00); // Init finished in time.
      chk(dac_code, {4{MID}}); // Midscale at power-up.
      chk_reg({strobe_mask, reference_off}, 5'h00); // Mask clear, reference on.
      $display("test por done");
   endtask : t_por

   task automatic t_defer;
      i_master.send(8'h11, 8'h12, 8'h34);
      wait_clk(1);
      chk(input_code, {{3{MID}}, 16'h1234}); // Input register written.
      chk(dac_code, {4{MID}}); // Output waits for the strobe.
      @(posedge clk) load_strobe_n <= 1'b0;
      wait_clk(8);
      chk(dac_code, {{3{MID}}, 16'h1234}); // Falling strobe loads output.
      @(posedge clk) load_strobe_n <= 1'b1;
      wait_clk(8);
      $display("test defer done");
   endtask : t_defer

   task automatic t_cmds;
      i_master.send(8'h12, 8'h56, 8'h78);
      i_master.send(8'h22, 8'hff, 8'hff);
      wait_clk(1);
      chk(input_code, {{2{MID}}, 16'h5678, 16'h1234}); // Input kept.
      chk(dac_code, {{2{MID}}, 16'h5678, 16'h1234}); // Output copied.
      i_master.send(8'h38, 8'h9a, 8'hbc);
      wait_clk(1);
      chk(dac_code, {16'h9abc, MID, 16'h5678, 16'h1234}); // Output loaded at once.
      $display("test cmds done");
   endtask : t_cmds

   task automatic t_mask;
      i_master.send(8'h5f, 8'hff, 8'hf5);
      wait_clk(1);
      chk_reg({strobe_mask, reference_off}, 5'h0a); // Low nibble taken.
      i_master.send(8'h1f, 8'h11, 8'h11);
      @(posedge clk) load_strobe_n <= 1'b0;
      wait_clk(8);
      chk(dac_code, {16'h1111, MID, 16'h1111, 16'h1234}); // Masked ones kept.
      $display("test mask done");
   endtask : t_mask

   task automatic t_low;
      i_master.send(8'h11, 8'h22, 8'h22);
      wait_clk(1);
      chk(dac_code, {16'h1111, MID, 16'h1111, 16'h2222}); // Mask bypassed.
      @(posedge clk) load_strobe_n <= 1'b1;
      wait_clk(8);
      $display("test low done");
   endtask : t_low

   task automatic t_ref;
      i_master.send(8'h7f, 8'hff, 8'hfe);
      wait_clk(1);
      chk_reg({strobe_mask, reference_off}, 5'h0a); // Zero keeps it on.
      i_master.send(8'h70, 8'h00, 8'h01);
      wait_clk(1);
      chk_reg({strobe_mask, reference_off}, 5'h0b); // One turns it off.
      $display("test ref done");
   endtask : t_ref

   task automatic t_hwrst;
      @(posedge clk);
      hw_reset_n <= 1'b0;
      reset_level_select <= 1'b0;
      wait_clk(8);
      chk(dac_code, 64'h0); // Cleared to zero scale.
      i_master.send(8'h3f, 8'h44, 8'h44);
      wait_clk(1);
      chk(dac_code, 64'h0); // Writes blocked.
      @(posedge clk) hw_reset_n <= 1'b1;
      wait_clk(8);
      chk(dac_code, 64'h0); // Cleared value held.
      i_master.send(8'h3f, 8'h44, 8'h44);
      wait_clk(1);
      chk(dac_code, {4{16'h4444}}); // New value accepted.
      $display("test hwrst done");
   endtask : t_hwrst

   task automatic t_softrst;
      @(posedge clk) reset_level_select <= 1'b1;
      wait_clk(8);
      i_master.send(8'h60, 8'h00, 8'h00);
      wait_clk(1);
      chk(dac_code, {4{MID}}); // Power-on code back.
      chk_reg({strobe_mask, reference_off}, 5'h00); // Mask and reference reset.
      i_master.send(8'h4f, 8'h12, 8'h34);
      i_master.send(8'h8f, 8'h12, 8'h34);
      wait_clk(1);
      chk(dac_code, {4{MID}}); // Other codes leave outputs.
      chk(input_code, {4{MID}}); // Input registers kept.
      $display("test softrst done");
   endtask : t_softrst

   task automatic summarize;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_por();
      t_defer();
      t_cmds();
      t_mask();
      t_low();
      t_ref();
      t_hwrst();
      t_softrst();
      summarize();
   end

   initial begin
      #20000;
      fails++;
      summarize();
   end
endmodule : testbench

`default_nettype wire
